// >>> logic/ftcr_map.svh
// Offsets, field positions, reset values and timing figures of the configuration bank
`ifndef FTCR_MAP_SVH
`define FTCR_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define FTCR_OFS_CFG0            8'h00
`define FTCR_OFS_CFG1            8'h01
`define FTCR_OFS_FAN_PWM_CONFIG  8'h02
`define FTCR_OFS_MISC_IO_CONFIG  8'h03
`define FTCR_OFS_TACH_ENABLE     8'h07
`define FTCR_OFS_TACH_CONT       8'h08
`define FTCR_OFS_UNLOCK          8'h7B

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FTCR_CFG0_SW_RESET_BIT   7
`define FTCR_CFG1_LOCK_BIT       6
`define FTCR_PWM_FAST_BIT        0
`define FTCR_PWM_MODE_BIT        2
`define FTCR_PWM_HOT1_MASK_BIT   3
`define FTCR_PWM_HOT2_MASK_BIT   4
`define FTCR_PWM_FULL_SPEED_BIT  5
`define FTCR_PWM_PULSES_MSB      7
`define FTCR_PWM_PULSES_LSB      6
`define FTCR_MISC_CI_CLEAR_BIT   5
`define FTCR_CONT_PAIRS_MSB      3
`define FTCR_CONT_RES_MSB        7
`define FTCR_CONT_RES_LSB        4

// ----------------------------------------------------------------------------
// Reset values and keys
// ----------------------------------------------------------------------------
`define FTCR_RST_FAN_PWM_CONFIG  8'h40
`define FTCR_RST_MISC_IO_CONFIG  8'h00
`define FTCR_RST_TACH_ENABLE     8'h00
`define FTCR_RST_TACH_CONT       8'hE0
`define FTCR_UNLOCK_KEY          8'h6D

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FTCR_CLK_FREQ_KHZ        250000
`define FTCR_MEAS_SLOW_MS        1000
`define FTCR_MEAS_FAST_MS        250

`endif

// >>> logic/ftcr_pkg.sv
// Types shared by the fan and tach_continuous_config bank
package ftcr_pkg;

    // ------------------------------------------------------------------------
    // Register port request
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ftcr_reg_req_type;

    // ------------------------------------------------------------------------
    // Miscellaneous I/O controls, laid out as the register bits 7..0
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic core_low_en;
        logic xor_tree_en;
        logic intrusion_latch_clear;
        logic thermal_pin_input_level;
        logic voltage_id_input_level;
        logic sda_timeout_en;
        logic scl_timeout_en;
        logic gpio_enable;
    } ftcr_misc_ctrl_type;

    // ------------------------------------------------------------------------
    // Tach period meter states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        FTCR_TACH_IDLE,
        FTCR_TACH_FIRST,
        FTCR_TACH_SECOND,
        FTCR_TACH_COUNT
    } ftcr_tach_state_type;

endpackage

// >>> logic/ftcr_tach_period.sv
// Period meter for one tach input: second rising edge to x pulses later
`timescale 1ns/100ps
module ftcr_tach_period
    import ftcr_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    input  wire logic             start_i,
    input  wire logic             enable_i,
    input  wire logic             tach_i,
    input  wire logic [1:0]       pulses_sel_i,
    output logic                  busy_o,
    output logic                  done_o,
    output logic [CNT_W-1:0]      period_o
);

    ftcr_tach_state_type state;
    logic                tach_prev;
    logic [CNT_W-1:0]    cnt;
    logic [1:0]          edges;
    logic                rise;

    assign rise   = tach_i & ~tach_prev;
    assign busy_o = (state != FTCR_TACH_IDLE);

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tach_prev <= 1'b0;
        else
            tach_prev <= tach_i;
    end

    // ------------------------------------------------------------------------
    // Edge sequencer
    // ------------------------------------------------------------------------
    // Counter saturation doubles as a stall timeout, so a stopped fan
    // still ends the measurement with an all-ones period.
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state    <= FTCR_TACH_IDLE;
            cnt      <= '0;
            edges    <= 2'h0;
            done_o   <= 1'b0;
            period_o <= '0;
        end
        else
        begin
            done_o <= 1'b0;
            if (!enable_i)
                state <= FTCR_TACH_IDLE;
            else if (state != FTCR_TACH_IDLE && cnt == '1)
            begin
                state    <= FTCR_TACH_IDLE;
                done_o   <= 1'b1;
                period_o <= '1;
            end
            else
            begin
                case (state)
                    FTCR_TACH_IDLE:
                    begin
                        if (start_i)
                        begin
                            state <= FTCR_TACH_FIRST;
                            cnt   <= '0;
                        end
                    end
                    FTCR_TACH_FIRST:
                    begin
                        cnt <= cnt + 1'b1;
                        if (rise)
                            state <= FTCR_TACH_SECOND;
                    end
                    FTCR_TACH_SECOND:
                    begin
                        cnt <= cnt + 1'b1;
                        if (rise)
                        begin
                            state <= FTCR_TACH_COUNT;
                            cnt   <= '0;
                            edges <= 2'h0;
                        end
                    end
                    FTCR_TACH_COUNT:
                    begin
                        cnt <= cnt + 1'b1;
                        if (rise)
                        begin
                            if (edges == pulses_sel_i)
                            begin
                                state    <= FTCR_TACH_IDLE;
                                done_o   <= 1'b1;
                                period_o <= cnt + 1'b1;
                            end
                            else
                                edges <= edges + 2'h1;
                        end
                    end
                    default:
                        state <= FTCR_TACH_IDLE;
                endcase
            end
        end
    end

endmodule // ftcr_tach_period

// >>> logic/ftcr_config_regs.sv
// Fan PWM, tach measurement and miscellaneous I/O configuration bank
//
// Notes on behaviour
// - Low-frequency measure rate 1/s, fast bit 4/s
// - Mode bit: 0 low-frequency PWM, 1 high
// - Hot input 1 forces full speed unless masked
// - Hot input 2 forces full speed unless masked
// - Full-speed bit drives every fan flat out
// - Low-frequency mode stretches PWM while measuring non-continuous pairs
// - Period from second edge to x pulses later
// - Misc bit 0 enables general-purpose I/O pins
// - Misc bit 1 enables clock-line timeout
// - Misc bit 2 enables data-line timeout
// - Misc bit 3 picks low voltage-id threshold
// - Misc bit 4 picks low thermal-pin threshold
// - Misc bit 5 clears intrusion latch, self-clears
// - Misc bit 6 enables connectivity test tree
// - Misc bit 7 enables core-supply-low function
// - Tach enable bit n enables input n+1
// - Pair bits enable continuous low-frequency measurement
// - Upper tach-config bits reserved, read-only
// - PWM config resets to 0x40, lockable
// - Tach config resets to 0xE0, lockable
// - Lock bit makes lockable registers read-only
`timescale 1ns/100ps
`include "ftcr_map.svh"
module ftcr_config_regs
    import ftcr_pkg::*;
#(
    parameter int NUM_TACH    = 8,
    parameter int PERIOD_W    = 16,
    parameter int SLOW_CYCLES = `FTCR_MEAS_SLOW_MS * `FTCR_CLK_FREQ_KHZ,
    parameter int FAST_CYCLES = `FTCR_MEAS_FAST_MS * `FTCR_CLK_FREQ_KHZ
)
(
    input  wire logic                         clk_sys_i,
    input  wire logic                         rst_n_i,
    input  wire ftcr_reg_req_type             reg_req_i,
    output logic [7:0]                        rd_data_o,
    output logic                              rd_valid_o,
    input  wire logic                         regulator_hot_input_1_i,
    input  wire logic                         regulator_hot_input_2_i,
    input  wire logic [NUM_TACH-1:0]          fan_speed_input_i,
    output logic                              fan_full_speed_o,
    output logic                              pwm_high_freq_o,
    output logic [NUM_TACH/2-1:0]             pwm_stretch_o,
    output logic [1:0]                        pulse_count_select_o,
    output ftcr_misc_ctrl_type                misc_ctrl_o,
    output logic                              locked_o,
    output logic [NUM_TACH-1:0]               tach_valid_o,
    output logic [NUM_TACH-1:0][PERIOD_W-1:0] tach_period_o
);

    localparam int NUM_PAIRS = NUM_TACH / 2;
    localparam int MEAS_W    = 28;
    // A literal cannot be part-selected, so the tach config reset value lives here
    localparam logic [7:0] TACH_CONT_RST = `FTCR_RST_TACH_CONT;

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------------
    logic [7:0]           fan_pwm_config;
    logic [7:0]           misc_io_config;
    logic [7:0]           tach_channel_enable;
    logic [NUM_PAIRS-1:0] pair_continuous_measure;
    logic                 lock_set;
    logic [7:0]           unlock_key;

    logic wr_hit;
    logic sw_reset_hit;
    logic low_freq;

    assign wr_hit   = reg_req_i.wr_en & ~lock_set;
    assign low_freq = ~fan_pwm_config[`FTCR_PWM_MODE_BIT];

    // Reset needs the key already in place; register defaults load only while unlocked, but the key clears even when locked.
    assign sw_reset_hit = reg_req_i.wr_en
                        & (reg_req_i.addr == `FTCR_OFS_CFG0)
                        & reg_req_i.wdata[`FTCR_CFG0_SW_RESET_BIT]
                        & (unlock_key == `FTCR_UNLOCK_KEY);

    // Lock survives software reset; only a power-on clears it.
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            lock_set <= 1'b0;
        else if (reg_req_i.wr_en && reg_req_i.addr == `FTCR_OFS_CFG1
                 && reg_req_i.wdata[`FTCR_CFG1_LOCK_BIT])
            lock_set <= 1'b1;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            unlock_key <= 8'h00;
        else if (sw_reset_hit)
            unlock_key <= 8'h00;
        else if (reg_req_i.wr_en && reg_req_i.addr == `FTCR_OFS_UNLOCK)
            unlock_key <= reg_req_i.wdata;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fan_pwm_config          <= `FTCR_RST_FAN_PWM_CONFIG;
            misc_io_config          <= `FTCR_RST_MISC_IO_CONFIG;
            tach_channel_enable     <= `FTCR_RST_TACH_ENABLE;
            pair_continuous_measure <= TACH_CONT_RST[`FTCR_CONT_PAIRS_MSB:0];
        end
        else if (sw_reset_hit && !lock_set)
        begin
            fan_pwm_config          <= `FTCR_RST_FAN_PWM_CONFIG;
            misc_io_config          <= `FTCR_RST_MISC_IO_CONFIG;
            tach_channel_enable     <= `FTCR_RST_TACH_ENABLE;
            pair_continuous_measure <= TACH_CONT_RST[`FTCR_CONT_PAIRS_MSB:0];
        end
        else
        begin
            // Intrusion clear is a one-cycle pulse by design
            misc_io_config[`FTCR_MISC_CI_CLEAR_BIT] <= 1'b0;
            if (wr_hit && reg_req_i.addr == `FTCR_OFS_FAN_PWM_CONFIG)
                fan_pwm_config <= reg_req_i.wdata;
            else if (wr_hit && reg_req_i.addr == `FTCR_OFS_MISC_IO_CONFIG)
                misc_io_config <= reg_req_i.wdata;
            else if (wr_hit && reg_req_i.addr == `FTCR_OFS_TACH_ENABLE)
                tach_channel_enable <= reg_req_i.wdata;
            else if (wr_hit && reg_req_i.addr == `FTCR_OFS_TACH_CONT)
                pair_continuous_measure <=
                    reg_req_i.wdata[`FTCR_CONT_PAIRS_MSB:0];
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    logic [7:0] next_rd_data;

    always_comb
    begin
        next_rd_data = 8'h00;
        if (reg_req_i.addr == `FTCR_OFS_CFG1)
            next_rd_data[`FTCR_CFG1_LOCK_BIT] = lock_set;
        else if (reg_req_i.addr == `FTCR_OFS_FAN_PWM_CONFIG)
            next_rd_data = fan_pwm_config;
        else if (reg_req_i.addr == `FTCR_OFS_MISC_IO_CONFIG)
            next_rd_data = misc_io_config;
        else if (reg_req_i.addr == `FTCR_OFS_TACH_ENABLE)
            next_rd_data = tach_channel_enable;
        else if (reg_req_i.addr == `FTCR_OFS_TACH_CONT)
            next_rd_data = {TACH_CONT_RST[`FTCR_CONT_RES_MSB:`FTCR_CONT_RES_LSB],
                            pair_continuous_measure};
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_o  <= 8'h00;
            rd_valid_o <= 1'b0;
        end
        else
        begin
            rd_valid_o <= reg_req_i.rd_en;
            if (reg_req_i.rd_en)
                rd_data_o <= next_rd_data;
        end
    end

    // ------------------------------------------------------------------------
    // Fan speed override
    // ------------------------------------------------------------------------
    logic next_full_speed;

    always_comb
    begin
        next_full_speed = fan_pwm_config[`FTCR_PWM_FULL_SPEED_BIT];
        if (regulator_hot_input_1_i && !fan_pwm_config[`FTCR_PWM_HOT1_MASK_BIT])
            next_full_speed = 1'b1;
        if (regulator_hot_input_2_i && !fan_pwm_config[`FTCR_PWM_HOT2_MASK_BIT])
            next_full_speed = 1'b1;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            fan_full_speed_o <= 1'b0;
        else
            fan_full_speed_o <= next_full_speed;
    end

    // ------------------------------------------------------------------------
    // Static controls
    // ------------------------------------------------------------------------
    assign pwm_high_freq_o      = fan_pwm_config[`FTCR_PWM_MODE_BIT];
    assign pulse_count_select_o =
        fan_pwm_config[`FTCR_PWM_PULSES_MSB:`FTCR_PWM_PULSES_LSB];
    assign misc_ctrl_o          = ftcr_misc_ctrl_type'(misc_io_config);
    assign locked_o             = lock_set;

    // ------------------------------------------------------------------------
    // Measurement rate timer
    // ------------------------------------------------------------------------
    // Slow rate also serves high-frequency mode, where the fast bit has no say.
    logic [MEAS_W-1:0] meas_cnt;
    logic [MEAS_W-1:0] meas_limit;
    logic              meas_tick;

    always_comb
    begin
        if (low_freq && fan_pwm_config[`FTCR_PWM_FAST_BIT])
            meas_limit = MEAS_W'(FAST_CYCLES - 1);
        else
            meas_limit = MEAS_W'(SLOW_CYCLES - 1);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meas_cnt  <= '0;
            meas_tick <= 1'b0;
        end
        else if (meas_cnt >= meas_limit)
        begin
            meas_cnt  <= '0;
            meas_tick <= 1'b1;
        end
        else
        begin
            meas_cnt  <= meas_cnt + 1'b1;
            meas_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Per-channel period meters
    // ------------------------------------------------------------------------
    logic [NUM_TACH-1:0] meter_busy;
    logic [NUM_TACH-1:0] meter_done;
    logic [NUM_TACH-1:0] meter_start;
    logic [NUM_TACH-1:0] cont_chan;

    for (genvar ch = 0; ch < NUM_TACH; ch++)
    begin : g_tach
        assign cont_chan[ch]   = low_freq & pair_continuous_measure[ch % NUM_PAIRS];
        // Continuous pairs rearm straight from their own completion
        assign meter_start[ch] = meas_tick | (cont_chan[ch] & meter_done[ch]);

        ftcr_tach_period #(
            .CNT_W        (PERIOD_W)
        ) u_meter (
            .clk_sys_i    (clk_sys_i),
            .rst_n_i      (rst_n),
            .start_i      (meter_start[ch]),
            .enable_i     (tach_channel_enable[ch]),
            .tach_i       (fan_speed_input_i[ch]),
            .pulses_sel_i (fan_pwm_config[`FTCR_PWM_PULSES_MSB:`FTCR_PWM_PULSES_LSB]),
            .busy_o       (meter_busy[ch]),
            .done_o       (meter_done[ch]),
            .period_o     (tach_period_o[ch])
        );
    end

    assign tach_valid_o = meter_done;

    // ------------------------------------------------------------------------
    // Pulse stretch
    // ------------------------------------------------------------------------
    // Continuous pairs are measured without stretching the shared PWM output.
    logic [NUM_PAIRS-1:0] next_stretch;

    always_comb
    begin
        next_stretch = '0;
        for (int p = 0; p < NUM_PAIRS; p++)
            next_stretch[p] = low_freq & ~pair_continuous_measure[p]
                            & (meter_busy[p] | meter_busy[p + NUM_PAIRS]);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            pwm_stretch_o <= '0;
        else
            pwm_stretch_o <= next_stretch;
    end

endmodule // ftcr_config_regs

// >>> verif/ftcr_config_regs_chk.sv
// Assertion checker for the fan and tach_continuous_config bank
`timescale 1ns/100ps
module ftcr_config_regs_chk
    import ftcr_pkg::*;
#(
    parameter int NUM_TACH = 8
)
(
    input  wire logic               clk_sys_i,
    input  wire logic               rst_n_i,
    input  wire ftcr_reg_req_type   reg_req_i,
    input  wire logic [7:0]         rd_data_o,
    input  wire logic               rd_valid_o,
    input  wire logic               regulator_hot_input_1_i,
    input  wire logic               regulator_hot_input_2_i,
    input  wire logic               fan_full_speed_o,
    input  wire logic               pwm_high_freq_o,
    input  wire logic [1:0]         pulse_count_select_o,
    input  wire ftcr_misc_ctrl_type misc_ctrl_o,
    input  wire logic               locked_o,
    input  wire logic [NUM_TACH-1:0] tach_valid_o
);
    logic wr2;
    logic wr3;
    logic cause;

    assign wr2 = reg_req_i.wr_en && reg_req_i.addr == 8'h02 && !locked_o;
    assign wr3 = reg_req_i.wr_en && reg_req_i.addr == 8'h03 && !locked_o;
    // Write or register path may add one stage, so accept both depths
    assign cause = regulator_hot_input_1_i || regulator_hot_input_2_i
                   || (wr2 && reg_req_i.wdata[5]);

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence clr_pulse_s;
        misc_ctrl_o.intrusion_latch_clear ##1 !misc_ctrl_o.intrusion_latch_clear;
    endsequence

    rsvd_bits_a: assert property (
        reg_req_i.rd_en && reg_req_i.addr == 8'h08 |=> rd_valid_o && rd_data_o[7:4] == 4'hE)
        else $error("reserved tach config bits not 1110");
    mode_wr_a: assert property (
        wr2 |=> pwm_high_freq_o == $past(reg_req_i.wdata[2]))
        else $error("mode bit not taken");
    pulses_wr_a: assert property (
        wr2 |=> pulse_count_select_o == $past(reg_req_i.wdata[7:6]))
        else $error("pulse count field not taken");
    misc_wr_a: assert property (
        wr3 |=> {misc_ctrl_o[7:6], misc_ctrl_o[4:0]} ==
                {$past(reg_req_i.wdata[7:6]), $past(reg_req_i.wdata[4:0])})
        else $error("misc controls not taken");
    clr_once_a: assert property (
        wr3 && reg_req_i.wdata[5] ##1 !wr3 |-> clr_pulse_s)
        else $error("intrusion clear not a single pulse");
    lock_stays_a: assert property (
        locked_o |=> locked_o)
        else $error("lock released");
    lock_freeze_a: assert property (
        locked_o && reg_req_i.wr_en && reg_req_i.addr == 8'h02
        |=> $stable(pwm_high_freq_o) && $stable(pulse_count_select_o))
        else $error("locked register changed");
    full_cause_a: assert property (
        $rose(fan_full_speed_o) |-> $past(cause) || $past(cause, 2))
        else $error("full speed without cause");
    valid_pulse_a: assert property (
        tach_valid_o[0] |=> !tach_valid_o[0])
        else $error("tach valid longer than one cycle");
endmodule // ftcr_config_regs_chk

bind ftcr_config_regs ftcr_config_regs_chk #(.NUM_TACH(NUM_TACH)) ftcr_config_regs_chk_i (
    .clk_sys_i, .rst_n_i, .reg_req_i, .rd_data_o, .rd_valid_o,
    .regulator_hot_input_1_i, .regulator_hot_input_2_i, .fan_full_speed_o,
    .pwm_high_freq_o, .pulse_count_select_o, .misc_ctrl_o, .locked_o, .tach_valid_o
);

// >>> verif/ftcr_fan_model.sv
// Eight free-running fans, each with its own tach period
`timescale 1ns/100ps
module ftcr_fan_model
#(
    parameter int HALF = 10
)
(
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    output logic [7:0]      tach_o
);
    int cnt [8];

    // Channel i toggles every HALF+i+1 cycles, so no two fans match
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tach_o <= 8'h00;
            foreach (cnt[i]) cnt[i] <= 0;
        end
        else
        begin
            foreach (cnt[i])
            begin
                cnt[i] <= (cnt[i] >= HALF + i) ? 0 : cnt[i] + 1;
                if (cnt[i] >= HALF + i) tach_o[i] <= !tach_o[i];
            end
        end
    end
endmodule // ftcr_fan_model

// >>> verif/testbench.sv
// Self-checking bench for the fan and tach_continuous_config bank
`timescale 1ns/100ps
module testbench
    import ftcr_pkg::*;
;
    localparam int T0 = 22;
    logic               clk_sys_i = 1'b0;
    logic               rst_n_i = 1'b0;
    ftcr_reg_req_type   reg_req_i = '0;
    logic               regulator_hot_input_1_i = 1'b0;
    logic               regulator_hot_input_2_i = 1'b0;
    logic [7:0]         fan_speed_input_i;
    logic [7:0]         rd_data_o;
    logic               rd_valid_o;
    logic               fan_full_speed_o;
    logic               pwm_high_freq_o;
    logic [3:0]         pwm_stretch_o;
    logic [1:0]         pulse_count_select_o;
    ftcr_misc_ctrl_type misc_ctrl_o;
    logic               locked_o;
    logic [7:0]         tach_valid_o;
    logic [7:0][15:0]   tach_period_o;
    logic [10:0]        fs_tab [7] = '{11'h005, 11'h044, 11'h003, 11'h082,
                                       11'h0C6, 11'h101, 11'h000};
    int                 err_total = 0;
    int                 checks_done = 0;
    int                 n;
    bit                 st;

    ftcr_config_regs #(.SLOW_CYCLES(400), .FAST_CYCLES(100)) ftcr_config_regs_i (
        .clk_sys_i, .rst_n_i, .reg_req_i, .rd_data_o, .rd_valid_o,
        .regulator_hot_input_1_i, .regulator_hot_input_2_i, .fan_speed_input_i,
        .fan_full_speed_o, .pwm_high_freq_o, .pwm_stretch_o, .pulse_count_select_o,
        .misc_ctrl_o, .locked_o, .tach_valid_o, .tach_period_o);
    ftcr_fan_model #(.HALF(10)) ftcr_fan_model_i (
        .clk_sys_i, .rst_n_i, .tach_o(fan_speed_input_i));

    always #2 clk_sys_i = !clk_sys_i;

    task automatic chk(input bit ok, input string m);
        checks_done++;
        if (!ok)
        begin
            err_total++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1 reg_req_i = '{1'b1, 1'b0, a, d};
        @(posedge clk_sys_i);
        #1 reg_req_i = '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        #1 reg_req_i = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys_i);
        #1 reg_req_i = '0;
        chk(rd_valid_o === 1'b1 && rd_data_o === e, "read data");
    endtask

    // Cycles to the next period result on channel 0, stretch seen meanwhile
    task automatic wv(input int lim, output int c, output bit s);
        c = 0;
        s = 0;
        do
        begin
            @(posedge clk_sys_i);
            #1 c++;
            s |= pwm_stretch_o[0];
        end
        while (tach_valid_o[0] !== 1'b1 && c < lim);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #200000;
        err_total++;
        tally_and_finish();
    end

    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        #1 rst_n_i = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rd(8'h02, 8'h40);
        rd(8'h03, 8'h00);
        rd(8'h07, 8'h00);
        rd(8'h08, 8'hE0);
        rd(8'h55, 8'h00);
        wr(8'h03, 8'hFF);
        chk(misc_ctrl_o === 8'hFF, "misc controls");
        @(posedge clk_sys_i);
        #1 chk(misc_ctrl_o === 8'hDF, "intrusion clear stuck");
        rd(8'h03, 8'hDF);
        wr(8'h03, 8'h00);
        wr(8'h02, 8'h44);
        wr(8'h07, 8'hA5);
        wr(8'h08, 8'h0F);
        rd(8'h08, 8'hEF);
        rd(8'h07, 8'hA5);
        wr(8'h00, 8'h80);
        rd(8'h02, 8'h44);
        wr(8'h7B, 8'h6D);
        wr(8'h00, 8'h80);
        rd(8'h02, 8'h40);
        rd(8'h08, 8'hE0);
        rd(8'h07, 8'h00);
        foreach (fs_tab[i])
        begin
            wr(8'h02, fs_tab[i][10:3]);
            {regulator_hot_input_1_i, regulator_hot_input_2_i} = fs_tab[i][2:1];
            repeat (3) @(posedge clk_sys_i);
            #1 chk(fan_full_speed_o === fs_tab[i][0], "full speed");
        end
        wr(8'h07, 8'h01);
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h02, 8'(s << 6));
            wv(900, n, st);
            wv(900, n, st);
            chk(tach_period_o[0] === 16'((s + 1) * T0) && st, "tach period");
        end
        wr(8'h02, 8'h00);
        wv(900, n, st);
        wv(900, n, st);
        chk(n > 370 && n < 430, "slow rate");
        wr(8'h02, 8'h01);
        wv(900, n, st);
        wv(900, n, st);
        chk(n > 70 && n < 130, "fast rate");
        wr(8'h02, 8'h05);
        wv(900, n, st);
        wv(900, n, st);
        chk(n > 370 && n < 430 && !st && pwm_high_freq_o, "high freq");
        wr(8'h02, 8'h00);
        wr(8'h08, 8'h01);
        wv(900, n, st);
        wv(900, n, st);
        chk(n < 90, "continuous");
        wr(8'h08, 8'h00);
        wr(8'h07, 8'h00);
        wv(500, n, st);
        chk(n == 500, "disabled channel");
        wr(8'h07, 8'h03);
        wr(8'h01, 8'h40);
        chk(locked_o === 1'b1, "lock");
        rd(8'h01, 8'h40);
        wr(8'h02, 8'h44);
        rd(8'h02, 8'h00);
        wr(8'h7B, 8'h6D);
        wr(8'h00, 8'h80);
        rd(8'h07, 8'h03);
        tally_and_finish();
    end
endmodule // testbench
